/* inc/ussu_pkg.sv */
package ussu_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_DATA  = 8'h08;
  localparam logic [7:0] ADDR_PORT  = 8'h0C;
  localparam logic [7:0] ADDR_TIMER = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TC    = 0;  // clock_toggle_strobe
  localparam int CTRL_CLK   = 1;  // clock_strobe_bit
  localparam int CTRL_CS_LO = 2;  // clock_source_low_bit
  localparam int CTRL_CS_HI = 3;  // clock_source_high_bit
  localparam int CTRL_WM_LO = 4;  // wire_mode_low_bit
  localparam int CTRL_WM_HI = 5;  // wire_mode_high_bit
  localparam int STAT_SIF   = 7;  // start_condition_flag
  localparam int STAT_OIF   = 6;  // counter_overflow_flag
  localparam int PORT_DO    = 0;  // output latch bits
  localparam int PORT_SDA   = 1;
  localparam int PORT_SCL   = 2;
  localparam int DIR_DO     = 4;  // direction bits
  localparam int DIR_SDA    = 5;
  localparam int DIR_SCL    = 6;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] TIMER_RST = 8'h00;
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [3:0] CNT_MAX   = 4'hF;

  typedef enum logic [1:0] {
    WM_OFF      = 2'b00,
    WM_THREE    = 2'b01,
    WM_TWO      = 2'b10,
    WM_TWO_HOLD = 2'b11
  } ussu_wm_t;

  typedef enum logic [1:0] {
    CS_STROBE  = 2'b00,
    CS_TIMER   = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } ussu_cs_t;

  // true when a count event wraps the counter from fifteen to zero
  function automatic logic ussu_wraps(input logic [3:0] cnt, input logic inc);
    return inc && (cnt == CNT_MAX);
  endfunction : ussu_wraps

endpackage : ussu_pkg

/* inc/ussu_link_if.sv */
interface ussu_link_if;
  logic scl_lvl;    // synchronised clock line level
  logic sda_lvl;    // synchronised data line level
  logic scl_rise;   // one-cycle pulse per rising clock edge
  logic scl_fall;   // one-cycle pulse per falling clock edge
  logic start_det;  // data falls while clock stays high

  modport sync (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_det);
  modport core (input  scl_lvl, sda_lvl, scl_rise, scl_fall, start_det);
endinterface : ussu_link_if

/* hdl/ussu_pin_sync.sv */
module ussu_pin_sync
  import ussu_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   sda_raw,
  input  wire logic   scl_raw,
  ussu_link_if.sync   lk
);

  logic [1:0] sda_sync_r;
  logic [1:0] scl_sync_r;
  logic       sda_prev_r;
  logic       scl_prev_r;

  // ----------------------------------------------------------------
  // two-stage synchronisers; stage 0 feeds only stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_r <= 2'h3;
      scl_sync_r <= 2'h3;
      sda_prev_r <= 1'b1;
      scl_prev_r <= 1'b1;
    end else begin
      sda_sync_r <= {sda_sync_r[0], sda_raw};
      scl_sync_r <= {scl_sync_r[0], scl_raw};
      sda_prev_r <= sda_sync_r[1];
      scl_prev_r <= scl_sync_r[1];
    end
  end

  // edges and start condition seen on the synchronised levels
  assign lk.sda_lvl   = sda_sync_r[1];
  assign lk.scl_lvl   = scl_sync_r[1];
  assign lk.scl_rise  = scl_sync_r[1] & ~scl_prev_r;
  assign lk.scl_fall  = ~scl_sync_r[1] & scl_prev_r;
  assign lk.start_det = sda_prev_r & ~sda_sync_r[1] & scl_prev_r & scl_sync_r[1];

endmodule : ussu_pin_sync

/* hdl/ussu_top.sv */
module ussu_top
  import ussu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_match,
  input  wire logic        serial_data_in_pin,
  output logic             serial_data_in_pin_out,
  output logic             serial_data_in_pin_oe,
  input  wire logic        serial_clock_pin,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  output logic             data_out_pin,
  output logic             data_out_pin_oe,
  output logic             pullup_data_out,
  output logic             pullup_data_in,
  output logic             pullup_clock
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ussu_link_if lk ();

  ussu_wm_t    wm_r;
  ussu_cs_t    cs_r;
  logic        clk_sel_r;
  logic [7:0]  port_r;
  logic [7:0]  shreg_r;
  logic [3:0]  cnt_r;
  logic [7:0]  timer_r;
  logic        oif_r;
  logic        sif_r;
  logic        do_latch_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        do_o_r, do_oe_r, sda_o_r, sda_oe_r, scl_o_r, scl_oe_r;
  logic        pu_do_r, pu_sda_r, pu_scl_r;
  logic        do_o_nxt, do_oe_nxt, sda_o_nxt, sda_oe_nxt, scl_o_nxt, scl_oe_nxt;
  logic        pu_do_nxt, pu_sda_nxt, pu_scl_nxt;

  logic        setup, wr, wr_ctrl, wr_stat, wr_data, wr_port, wr_timer;
  logic        mapped;
  logic        ext, two_wire, hold;
  logic        sw_strobe, tc_strobe, samp_edge, out_edge;
  logic        shift_ev, count_ev, ovf_ev, start_ev, do_bit;
  logic [31:0] rd_mux;

  ussu_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sda_raw (serial_data_in_pin),
    .scl_raw (serial_clock_pin),
    .lk      (lk)
  );

  // ----------------------------------------------------------------
  // apb decode: zero wait states, pready rises in the access cycle
  // ----------------------------------------------------------------
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pready_r & pwrite;
  assign wr_ctrl  = wr & (paddr == ADDR_CTRL);
  assign wr_stat  = wr & (paddr == ADDR_STAT);
  assign wr_data  = wr & (paddr == ADDR_DATA);
  assign wr_port  = wr & (paddr == ADDR_PORT);
  assign wr_timer = wr & (paddr == ADDR_TIMER);
  assign mapped   = (paddr == ADDR_CTRL) | (paddr == ADDR_STAT) | (paddr == ADDR_DATA)
                  | (paddr == ADDR_PORT) | (paddr == ADDR_TIMER);

  // read mux; toggle strobe bit reads as zero, timer and counter read as one word
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:  rd_mux = {24'h00_0000, 2'h0, wm_r, cs_r, clk_sel_r, 1'b0};
      ADDR_STAT:  rd_mux = {24'h00_0000, sif_r, oif_r, 2'h0, cnt_r};
      ADDR_DATA:  rd_mux = {24'h00_0000, shreg_r};
      ADDR_PORT:  rd_mux = {24'h00_0000, 1'b0, port_r[6:4], 1'b0, port_r[2:0]};
      ADDR_TIMER: rd_mux = {20'h0_0000, timer_r, cnt_r};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wm_r      <= WM_OFF;
      cs_r      <= CS_STROBE;
      clk_sel_r <= 1'b0;
    end else if (wr_ctrl) begin
      wm_r      <= ussu_wm_t'(pwdata[CTRL_WM_HI:CTRL_WM_LO]);
      cs_r      <= ussu_cs_t'(pwdata[CTRL_CS_HI:CTRL_CS_LO]);
      clk_sel_r <= pwdata[CTRL_CLK];
    end
  end

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  assign ext       = cs_r[1];
  assign two_wire  = wm_r[1];
  assign sw_strobe = wr_ctrl & pwdata[CTRL_CLK] & (cs_r == CS_STROBE);
  assign tc_strobe = wr_ctrl & pwdata[CTRL_TC];
  // low source bit picks which pin edge samples; the other one drives out
  assign samp_edge = ext & (cs_r[0] ? lk.scl_fall : lk.scl_rise);
  assign out_edge  = ext & (cs_r[0] ? lk.scl_rise : lk.scl_fall);

  // shift and count events per source
  always_comb begin
    shift_ev = 1'b0;
    count_ev = 1'b0;
    case (cs_r)
      CS_STROBE: begin
        shift_ev = sw_strobe;
        count_ev = sw_strobe;
      end
      CS_TIMER: begin
        shift_ev = timer_match;
        count_ev = timer_match;
      end
      CS_EXT_POS, CS_EXT_NEG: begin
        shift_ev = samp_edge;
        // toggle strobe clocks the counter once the strobe bit is set
        count_ev = clk_sel_r ? tc_strobe : (lk.scl_rise | lk.scl_fall);
      end
      default: begin
        shift_ev = 1'b0;
        count_ev = 1'b0;
      end
    endcase
  end

  // a bus load of the counter wins over a count in the same cycle
  assign ovf_ev   = ussu_wraps(cnt_r, count_ev) & ~wr_stat;
  assign start_ev = two_wire & lk.start_det;

  // ----------------------------------------------------------------
  // four-bit counter and chained timer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CNT_RST;
    end else if (wr_stat) begin
      cnt_r <= pwdata[3:0];  // preset, e.g. to fifteen
    end else if (count_ev) begin
      cnt_r <= 4'(cnt_r + 4'h1);
    end
  end

  // overflow carries into the timer, giving a twelve-bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= TIMER_RST;
    end else if (wr_timer) begin
      timer_r <= pwdata[11:4];
    end else if (ovf_ev) begin
      timer_r <= 8'(timer_r + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // sticky flags: a new start beats a clear in the same cycle; a status write masks an overflow
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oif_r <= 1'b0;
    end else if (ovf_ev) begin
      oif_r <= 1'b1;
    end else if (wr_stat & pwdata[STAT_OIF]) begin
      oif_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif_r <= 1'b0;
    end else if (start_ev) begin
      sif_r <= 1'b1;
    end else if (wr_stat & pwdata[STAT_SIF]) begin
      sif_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shift register and output latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_r <= DATA_RST;
    end else if (wr_data) begin
      shreg_r <= pwdata[7:0];
    end else if (shift_ev) begin
      shreg_r <= {shreg_r[6:0], lk.sda_lvl};
    end
  end

  // external clock: output moves on the edge opposite to sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_latch_r <= 1'b0;
    end else if (out_edge) begin
      do_latch_r <= shreg_r[7];
    end
  end

  // other sources see the shifter directly, no extra latency
  assign do_bit = ext ? do_latch_r : shreg_r[7];

  // ----------------------------------------------------------------
  // port latch and direction; toggle strobe flips the clock latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_r <= PORT_RST;
    end else begin
      if (wr_port) begin
        port_r <= pwdata[7:0];
        port_r[PORT_SCL] <= pwdata[PORT_SCL] ^ tc_strobe;
      end else if (tc_strobe) begin
        port_r[PORT_SCL] <= ~port_r[PORT_SCL];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  assign hold = sif_r | ((wm_r == WM_TWO_HOLD) & oif_r);

  always_comb begin
    // ordinary port behaviour, wire mode zero
    do_o_nxt   = port_r[PORT_DO];
    do_oe_nxt  = port_r[DIR_DO];
    sda_o_nxt  = port_r[PORT_SDA];
    sda_oe_nxt = port_r[DIR_SDA];
    scl_o_nxt  = port_r[PORT_SCL];
    scl_oe_nxt = port_r[DIR_SCL];
    pu_do_nxt  = ~port_r[DIR_DO] & port_r[PORT_DO];
    pu_sda_nxt = ~port_r[DIR_SDA] & port_r[PORT_SDA];
    pu_scl_nxt = ~port_r[DIR_SCL] & port_r[PORT_SCL];
    case (wm_r)
      WM_THREE: begin
        do_o_nxt = do_bit;
      end
      WM_TWO, WM_TWO_HOLD: begin
        // open collector: only ever drive low
        sda_o_nxt  = 1'b0;
        sda_oe_nxt = port_r[DIR_SDA] & (~do_bit | ~port_r[PORT_SDA]);
        scl_o_nxt  = 1'b0;
        scl_oe_nxt = port_r[DIR_SCL] & (~port_r[PORT_SCL] | hold);
        pu_sda_nxt = 1'b0;
        pu_scl_nxt = 1'b0;
      end
      default: begin
        do_o_nxt = port_r[PORT_DO];
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_o_r   <= 1'b0;
      do_oe_r  <= 1'b0;
      sda_o_r  <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_o_r  <= 1'b0;
      scl_oe_r <= 1'b0;
      pu_do_r  <= 1'b0;
      pu_sda_r <= 1'b0;
      pu_scl_r <= 1'b0;
    end else begin
      do_o_r   <= do_o_nxt;
      do_oe_r  <= do_oe_nxt;
      sda_o_r  <= sda_o_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_o_r  <= scl_o_nxt;
      scl_oe_r <= scl_oe_nxt;
      pu_do_r  <= pu_do_nxt;
      pu_sda_r <= pu_sda_nxt;
      pu_scl_r <= pu_scl_nxt;
    end
  end

  assign prdata                 = prdata_r;
  assign pready                 = pready_r;
  assign pslverr                = pslverr_r;
  assign data_out_pin           = do_o_r;
  assign data_out_pin_oe        = do_oe_r;
  assign serial_data_in_pin_out = sda_o_r;
  assign serial_data_in_pin_oe  = sda_oe_r;
  assign serial_clock_pin_out   = scl_o_r;
  assign serial_clock_pin_oe    = scl_oe_r;
  assign pullup_data_out        = pu_do_r;
  assign pullup_data_in         = pu_sda_r;
  assign pullup_clock           = pu_scl_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ovf_sets;
    ovf_ev |=> oif_r;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

  property p_ovf_sticky;
    oif_r && !(wr_stat && pwdata[STAT_OIF]) |=> oif_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_both_edges;
    ext && !clk_sel_r && lk.scl_fall && !wr_stat |=> cnt_r == 4'($past(cnt_r) + 4'h1);
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("falling edge not counted");

  property p_chain;
    ovf_ev && !wr_timer |=> timer_r == 8'($past(timer_r) + 8'h01) && cnt_r == CNT_RST;
  endproperty
  a_chain: assert property (p_chain) else $error("timer carry missing");

  property p_strobe;
    sw_strobe && !wr_data |=> shreg_r == {$past(shreg_r[6:0]), $past(lk.sda_lvl)};
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not shift");

  property p_off_pins;
    wm_r == WM_OFF |=> data_out_pin == $past(port_r[PORT_DO]) && !pullup_data_in == $past(
      port_r[DIR_SDA] || !port_r[PORT_SDA]);
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("port pins not ordinary");

  property p_start_hold;
    two_wire && sif_r && port_r[DIR_SCL] ##1 two_wire && sif_r && port_r[DIR_SCL]
      |=> serial_clock_pin_oe && !serial_clock_pin_out;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("clock not held on start");

  property p_ovf_hold;
    wm_r == WM_TWO_HOLD && oif_r && port_r[DIR_SCL] |=> serial_clock_pin_oe;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("clock not held on overflow");

  property p_pullups;
    two_wire |=> !pullup_data_in && !pullup_clock;
  endproperty
  a_pullups: assert property (p_pullups) else $error("pull-up on in two-wire");

  property p_no_start_off;
    !two_wire && !sif_r |=> !sif_r;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start seen off two-wire");

  c_overflow:   cover property (ovf_ev && ext);
  c_start:      cover property (start_ev ##[1:50] (wr_stat && pwdata[STAT_SIF]));
  c_soft_int:   cover property (sw_strobe && cnt_r == CNT_MAX);
  c_two_wire:   cover property (wm_r == WM_TWO_HOLD && serial_clock_pin_oe);

endmodule : ussu_top

/* testbench/ussu_peer.sv */
module ussu_peer (
  input  wire logic sda_out,
  input  wire logic sda_oe,
  input  wire logic scl_out,
  input  wire logic scl_oe,
  output wire logic sda_wire,
  output wire logic scl_wire
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // open-collector lines of the remote party
  // ----------------------------------------------------------------
  logic sda_hold_n;  // peer pulls data low while zero
  logic scl_hold_n;  // peer pulls clock low while zero

  initial begin
    sda_hold_n = 1'b1;
    scl_hold_n = 1'b1;
  end

  // a released line floats to the pull-up, never to the last value
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_hold_n;
  assign scl_wire = (scl_oe ? scl_out : 1'b1) & scl_hold_n;

  // link clock edges, 400 ns period; clock stands still between frames
  // offset by 10 ns so no pin moves in the time step of a pclk edge
  task automatic edges(input int n);
    #10;
    repeat (n) begin
      #200 scl_hold_n = ~scl_hold_n;
    end
    #190;
  endtask : edges

  // data falls while the clock is high
  task automatic start_cond;
    #210 sda_hold_n = 1'b0;
    #390;
  endtask : start_cond

  // let go of the data line
  task automatic release_sda;
    #110 sda_hold_n = 1'b1;
    #90;
  endtask : release_sda
endmodule : ussu_peer

/* testbench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ussu_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, timer_match;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, sda_w, scl_w;
  logic        di_out, di_oe, ck_out, ck_oe, do_pin, do_oe, pu_do, pu_di, pu_ck;
  logic [8:0]  pins;
  logic [7:0]  regs [5] = '{ADDR_CTRL, ADDR_STAT, ADDR_DATA, ADDR_PORT, ADDR_TIMER};
  int          n_mismatch;
  int          cmp_count;

  // pin view packed so one compare covers a whole pin state
  assign pins = {ck_oe, ck_out, di_oe, di_out, do_oe, do_pin, pu_ck, pu_di, pu_do};

  ussu_top ussu_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_match(timer_match),
    .serial_data_in_pin(sda_w), .serial_data_in_pin_out(di_out),
    .serial_data_in_pin_oe(di_oe), .serial_clock_pin(scl_w),
    .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe),
    .data_out_pin(do_pin), .data_out_pin_oe(do_oe), .pullup_data_out(pu_do),
    .pullup_data_in(pu_di), .pullup_clock(pu_ck)
  );

  ussu_peer ussu_peer_i (
    .sda_out(di_out), .sda_oe(di_oe), .scl_out(ck_out), .scl_oe(ck_oe),
    .sda_wire(sda_w), .scl_wire(scl_w)
  );

  // 20 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // pin outputs are registered, so let them settle first
  task automatic chkp(input logic [8:0] exp, input logic [8:0] msk);
    repeat (3) @(posedge pclk);
    chk({23'h0, pins & msk}, {23'h0, exp});
  endtask : chkp

  // one apb transfer; an idle edge first keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic pulse;
    @(posedge pclk);
    timer_match <= 1'b1;
    @(posedge pclk);
    timer_match <= 1'b0;
  endtask : pulse

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_match = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdc(regs[i], 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    endt("reset_map");
    // plain port: direction and latch alone decide the pins
    wr(ADDR_PORT, 32'h27);
    chkp(9'h065, 9'h177);
    wr(ADDR_PORT, 32'h07);
    ussu_peer_i.start_cond();
    rdc(ADDR_STAT, 32'h0);
    ussu_peer_i.release_sda();
    endt("plain_port");
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_DATA, 32'h80);
    wr(ADDR_PORT, 32'h10);
    chkp(9'h018, 9'h15F);
    wr(ADDR_DATA, 32'h0);
    chkp(9'h010, 9'h15F);
    wr(ADDR_PORT, 32'h07);
    chkp(9'h007, 9'h157);
    endt("three_wire");
    wr(ADDR_CTRL, 32'h20);
    wr(ADDR_DATA, 32'h80);
    wr(ADDR_PORT, 32'h60);
    chkp(9'h140, 9'h1F7);
    chk({30'h0, sda_w, scl_w}, 32'h0);
    wr(ADDR_PORT, 32'h66);
    chkp(9'h000, 9'h1F7);
    chk({30'h0, sda_w, scl_w}, 32'h3);
    wr(ADDR_DATA, 32'h0);
    chkp(9'h040, 9'h1F7);
    wr(ADDR_PORT, 32'h07);
    chkp(9'h001, 9'h1F7);
    endt("two_wire");
    wr(ADDR_PORT, 32'h66);
    wr(ADDR_DATA, 32'h80);
    // clear the start left by the data fall of the last test
    wr(ADDR_STAT, 32'h80);
    ussu_peer_i.start_cond();
    rdc(ADDR_STAT, 32'h80);
    chkp(9'h100, 9'h1F7);
    ussu_peer_i.release_sda();
    wr(ADDR_STAT, 32'h80);
    chkp(9'h000, 9'h1F7);
    endt("start_hold");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_TIMER, 32'h50);
    wr(ADDR_STAT, 32'h0E);
    wr(ADDR_CTRL, 32'h02);
    rdc(ADDR_STAT, 32'h0F);
    wr(ADDR_CTRL, 32'h02);
    rdc(ADDR_STAT, 32'h40);
    rdc(ADDR_TIMER, 32'h060);
    wr(ADDR_CTRL, 32'h02);
    rdc(ADDR_STAT, 32'h41);
    wr(ADDR_STAT, 32'h40);
    rdc(ADDR_STAT, 32'h0);
    endt("strobe_count");
    // shift output high, so entering two-wire does not pull data low
    wr(ADDR_DATA, 32'hFF);
    wr(ADDR_CTRL, 32'h30);
    wr(ADDR_STAT, 32'h0F);
    wr(ADDR_CTRL, 32'h32);
    chkp(9'h100, 9'h1F7);
    wr(ADDR_STAT, 32'h40);
    chkp(9'h000, 9'h1F7);
    endt("overflow_hold");
    // timer match only counts when it is the chosen source
    wr(ADDR_STAT, 32'h03);
    pulse();
    rdc(ADDR_STAT, 32'h03);
    wr(ADDR_CTRL, 32'h04);
    pulse();
    rdc(ADDR_STAT, 32'h04);
    endt("timer_source");
    wr(ADDR_CTRL, 32'h08);
    wr(ADDR_PORT, 32'h0);
    wr(ADDR_STAT, 32'h0F);
    ussu_peer_i.edges(1);
    rdc(ADDR_STAT, 32'h40);
    ussu_peer_i.edges(3);
    rdc(ADDR_STAT, 32'h43);
    // the stored strobe bit picks toggle clocking for later toggle writes
    wr(ADDR_CTRL, 32'h0A);
    wr(ADDR_CTRL, 32'h0B);
    rdc(ADDR_STAT, 32'h44);
    rdc(ADDR_PORT, 32'h04);
    rdc(ADDR_CTRL, 32'h0A);
    wr(ADDR_CTRL, 32'h08);
    wr(ADDR_CTRL, 32'h09);
    rdc(ADDR_STAT, 32'h44);
    endt("external_clock");
    // three-wire on the pin clock: output moves only on falling edges
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_DATA, 32'h80);
    wr(ADDR_PORT, 32'h10);
    ussu_peer_i.edges(1);
    chkp(9'h018, 9'h018);
    wr(ADDR_DATA, 32'h0);
    ussu_peer_i.edges(1);
    chkp(9'h018, 9'h018);
    ussu_peer_i.edges(1);
    chkp(9'h010, 9'h018);
    endt("output_latch");
    complete_run();
  end
endmodule : tb
